// ---- core/ssc_pkg.sv ----
// constants, register map and types shared by the strength/cca/channel control block
package ssc_pkg;
    // timing: 50 MHz clock, 16 us symbol, 8-symbol averaging window
    localparam int CLK_NS = 20;
    localparam int SYM_NS = 16000;
    localparam int SYM_CYC = SYM_NS / CLK_NS;
    localparam int AVG_SYMS = 8;
    localparam int QUAL_CYC = AVG_SYMS * SYM_CYC;
    localparam int CAL_NS = 192000;
    localparam int CAL_CYC_DEF = CAL_NS / CLK_NS;
    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_MODEM = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_THRESH = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SYNTH = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_CONTROL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_STROBE = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_FRAME = 5'h18;
    // modem_control_register0 fields
    localparam int MODE_LSB = 0;
    localparam int ACS_BIT = 2;
    localparam int HYST_LSB = 3;
    localparam int INV_BIT = 6;
    // strobe bits
    localparam int STB_RX_ON = 0;
    localparam int STB_TX_ON = 1;
    localparam int STB_COND_TX = 2;
    localparam int STB_OFF = 3;
    // status fields
    localparam int STS_SV_BIT = 8;
    localparam int STS_CV_BIT = 9;
    localparam int STS_TXA_BIT = 10;
    localparam int STS_CAL_BIT = 11;
    localparam int STS_CLR_BIT = 12;
    // reset values
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic [2:0] HYST_RST = 3'h2;
    localparam logic [7:0] THR_RST = 8'he0;
    localparam logic [9:0] CARRIER_FREQUENCY_WORD_RST = 10'h165;
    localparam logic [15:0] TXC_RST = 16'ha0ff;
    // carrier arithmetic in MHz
    localparam logic [11:0] LO_BASE = 12'h800;
    localparam logic [11:0] IF_OFS = 12'h002;
    // clear channel modes
    localparam logic [1:0] CCM_ENERGY = 2'h1;
    localparam logic [1:0] CCM_DATA = 2'h2;
    localparam logic [1:0] CCM_BOTH = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX_CAL, ST_RX, ST_TX_CAL, ST_ACK_CAL, ST_TX
    } ssc_state_e;
endpackage

// ---- core/ssc_avg_if.sv ----
// link between the controller and its strength averager
`timescale 1ns/1ps
interface ssc_avg_if;
    logic tick;
    logic clr;
    logic signed [7:0] sample;
    logic signed [7:0] avg;
    logic valid;
    modport ctl (output tick, output clr, output sample, input avg, input valid);
    modport avg_side (input tick, input clr, input sample, output avg, output valid);
endinterface

// ---- core/ssc_avg.sv ----
// sliding average of the strength samples over the last n symbols
`timescale 1ns/1ps
module ssc_avg #(
    parameter int W = 8,
    parameter int N = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controller side
    ssc_avg_if.avg_side a
);
    import ssc_pkg::*;
    localparam int LN = $clog2(N);
    localparam int SW = W + LN;

    // elaboration guard: the shift-based divide needs a power-of-two window
    if (N < 2 || N != (1 << LN) || W != 8) begin : g_bad_size
        $error("ssc_avg: N must be a power of two and W must be 8");
    end

    typedef struct packed {
        logic [N-1:0][W-1:0] win;
        logic signed [SW-1:0] sum;
        logic [LN:0] cnt;
        logic signed [W-1:0] avg;
        logic v;
    } ssc_avg_s;

    ssc_avg_s r_reg;
    ssc_avg_s r_next;

    // running sum: add the newest symbol, drop the one leaving the window
    always_comb begin
        r_next = r_reg;
        if (a.clr) begin
            r_next = '0;
        end else if (a.tick) begin
            r_next.sum = r_reg.sum + SW'(a.sample) - SW'($signed(r_reg.win[N-1]));
            r_next.win = {r_reg.win[N-2:0], a.sample};
            if (r_reg.cnt != (LN+1)'(N)) begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end
            // valid only once the window is full
            r_next.v = (r_next.cnt == (LN+1)'(N));
            r_next.avg = W'(r_next.sum >>> LN);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign a.avg = r_reg.avg;
    assign a.valid = r_reg.v;
endmodule

// ---- core/ssc_ctrl.sv ----
// signal strength, clear channel, channel word and power control with avalon-mm registers
// Notes on behaviour
// - strength readable as 8-bit signed two's complement field
// - strength is the average of eight symbol periods, 128 us
// - strength-valid set only after eight symbols of enabled receiver
// - strength recomputed every symbol once valid while receiving
// - 7-bit average correlation over eight symbols after frame delimiter
// - with auto checksum, correlation, strength and checksum flag appended per frame
// - clear channel compares strength with host threshold in 1 dB steps
// - clear channel valid only after eight symbols of enabled receiver
// - host-set hysteresis on the energy threshold comparison
// - mode 1 energy, 2 no valid data, 3 both, 0 reserved
// - clear channel pin active high, inverted by a host bit
// - conditional transmit strobe starts transmission only on a clear channel
// - transmit-active status bit shows the transmit started
// - carrier MHz is 2048 plus the 10-bit frequency word
// - receive oscillator sits 2 MHz below carrier, transmit on carrier
// - oscillator calibrated on each receive, transmit or ack transmit entry
// - 5-bit power level in transmit control register, reset 0xA0FF
// - regulator follows the regulator enable pin
`timescale 1ns/1ps
module ssc_ctrl #(
    parameter int CAL_CYC = ssc_pkg::CAL_CYC_DEF
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // avalon-mm slave
    input wire logic [ssc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // demodulator measurements
    input wire logic signed [7:0] STRENGTH_SAMPLE,
    input wire logic [6:0] CORR_SAMPLE,
    input wire logic SFD_DETECT,
    input wire logic FRAME_DONE,
    input wire logic CRC_OK,
    input wire logic RX_FRAME_ACTIVE,
    input wire logic ACK_REQUEST,
    input wire logic TX_DONE,
    input wire logic REGULATOR_ENABLE_PIN,
    // radio control outputs
    output logic CCA_OUT,
    output logic RX_ENABLE,
    output logic TX_ENABLE,
    output logic CAL_ACTIVE,
    output logic [11:0] LO_CARRIER_FREQUENCY_WORD_MHZ,
    output logic [4:0] POWER_AMP_SETTING,
    output logic REGULATOR_ON,
    output logic APPEND_STROBE
);
    import ssc_pkg::*;

    // elaboration guard: the 14-bit timer cannot count further
    if (CAL_CYC < 1 || CAL_CYC > 16383) begin : g_bad_cal
        $error("ssc_ctrl: CAL_CYC must lie in 1..16383");
    end

    localparam logic [13:0] CAL_LAST = 14'(CAL_CYC - 1);
    localparam logic [9:0] SYM_LAST = 10'(SYM_CYC - 1);

    typedef struct packed {
        ssc_state_e st;
        logic [13:0] tmr;
        logic [9:0] sym;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] mode;
        logic acs;
        logic [2:0] hyst;
        logic inv;
        logic [7:0] thr;
        logic [9:0] carrier_frequency_word;
        logic [15:0] txc;
        logic clr_st;
        logic cbusy;
        logic [2:0] ccnt;
        logic [9:0] csum;
        logic [6:0] corr;
        logic [15:0] frm;
        logic app;
        logic [11:0] lo;
        logic [4:0] pa;
        logic reg_on;
        logic cca_pin;
    } ssc_ctrl_s;

    ssc_ctrl_s r_reg;
    ssc_ctrl_s r_next;
    ssc_avg_if avg_bus();

    logic req;
    logic wr_eff;
    logic rx_on;
    logic tick;
    logic valid;
    logic energy_ok;
    logic cca_ok;
    logic tx_active;
    logic [31:0] wd;
    logic [31:0] status_w;
    logic signed [8:0] lower;

    // merge write data into an old word under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    // one wait cycle per access; write lands on the edge with waitrequest low
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~r_reg.ack;
    assign wr_eff = AVS_WRITE & r_reg.ack;

    // symbol timing only runs while the receiver is on
    assign rx_on = (r_reg.st == ST_RX);
    assign tick = rx_on && (r_reg.sym == SYM_LAST);

    assign avg_bus.tick = tick;
    assign avg_bus.clr = ~rx_on;
    assign avg_bus.sample = STRENGTH_SAMPLE;
    assign valid = avg_bus.valid;

    ssc_avg #(.W(8), .N(AVG_SYMS)) u_avg (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .a(avg_bus.avg_side)
    );

    // busy threshold minus hysteresis releases the channel
    assign lower = $signed({r_reg.thr[7], r_reg.thr}) - $signed({6'h00, r_reg.hyst});

    // clear channel mode select; reserved mode never reports clear
    always_comb begin
        energy_ok = r_reg.clr_st;
        unique case (r_reg.mode)
            CCM_ENERGY: cca_ok = valid & energy_ok;
            CCM_DATA: cca_ok = valid & ~RX_FRAME_ACTIVE;
            CCM_BOTH: cca_ok = valid & energy_ok & ~RX_FRAME_ACTIVE;
            default: cca_ok = 1'b0;
        endcase
    end

    assign tx_active = (r_reg.st == ST_TX_CAL) || (r_reg.st == ST_ACK_CAL) || (r_reg.st == ST_TX);

    // status word; cca valid shares the eight-symbol qualification
    always_comb begin
        status_w = '0;
        status_w[7:0] = avg_bus.avg;
        status_w[STS_SV_BIT] = valid;
        status_w[STS_CV_BIT] = valid;
        status_w[STS_TXA_BIT] = tx_active;
        status_w[STS_CAL_BIT] = CAL_ACTIVE;
        status_w[STS_CLR_BIT] = cca_ok;
    end

    // all next-state logic: bus, fsm, measurements
    always_comb begin
        r_next = r_reg;
        r_next.ack = req & ~r_reg.ack;
        r_next.app = 1'b0;
        wd = '0;
        // read data captured on the first edge, presented at the answering edge
        if (req && !r_reg.ack) begin
            unique case (AVS_ADDRESS)
                OFS_MODEM: r_next.rdata = {25'h0, r_reg.inv, r_reg.hyst, r_reg.acs, r_reg.mode};
                OFS_THRESH: r_next.rdata = {24'h0, r_reg.thr};
                OFS_SYNTH: r_next.rdata = {22'h0, r_reg.carrier_frequency_word};
                OFS_TX_CONTROL: r_next.rdata = {16'h0, r_reg.txc};
                OFS_STATUS: r_next.rdata = status_w;
                OFS_FRAME: r_next.rdata = {16'h0, r_reg.frm};
                default: r_next.rdata = '0;
            endcase
        end
        if (wr_eff) begin
            unique case (AVS_ADDRESS)
                OFS_MODEM: begin
                    wd = merge({25'h0, r_reg.inv, r_reg.hyst, r_reg.acs, r_reg.mode},
                               AVS_WRITEDATA, AVS_BYTEENABLE);
                    r_next.mode = wd[MODE_LSB +: 2];
                    r_next.acs = wd[ACS_BIT];
                    r_next.hyst = wd[HYST_LSB +: 3];
                    r_next.inv = wd[INV_BIT];
                end
                OFS_THRESH: r_next.thr = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : r_reg.thr;
                OFS_SYNTH: begin
                    wd = merge({22'h0, r_reg.carrier_frequency_word}, AVS_WRITEDATA, AVS_BYTEENABLE);
                    r_next.carrier_frequency_word = wd[9:0];
                end
                OFS_TX_CONTROL: begin
                    wd = merge({16'h0, r_reg.txc}, AVS_WRITEDATA, AVS_BYTEENABLE);
                    r_next.txc = wd[15:0];
                end
                OFS_STROBE: wd = merge(32'h0, AVS_WRITEDATA, AVS_BYTEENABLE);
                default: wd = '0;
            endcase
            if (AVS_ADDRESS != OFS_STROBE) begin
                wd = '0;
            end
        end

        // radio sequencer; calibration timer restarts on every state change
        r_next.tmr = r_reg.tmr + 14'h0001;
        unique case (r_reg.st)
            ST_IDLE: begin
                if (wd[STB_TX_ON]) begin
                    r_next.st = ST_TX_CAL;
                end else if (wd[STB_RX_ON]) begin
                    r_next.st = ST_RX_CAL;
                end
            end
            ST_RX_CAL, ST_TX_CAL, ST_ACK_CAL: begin
                if (r_reg.tmr == CAL_LAST) begin
                    r_next.st = (r_reg.st == ST_RX_CAL) ? ST_RX : ST_TX;
                end
            end
            ST_RX: begin
                // conditional start needs a clear channel
                if (wd[STB_TX_ON] || (wd[STB_COND_TX] && cca_ok)) begin
                    r_next.st = ST_TX_CAL;
                end else if (ACK_REQUEST) begin
                    r_next.st = ST_ACK_CAL;
                end
            end
            ST_TX: begin
                if (TX_DONE) begin
                    r_next.st = ST_RX_CAL;
                end
            end
            default: r_next.st = ST_IDLE; // unused codes fall back to idle
        endcase
        if (wd[STB_OFF]) begin
            r_next.st = ST_IDLE;
        end
        if (r_next.st != r_reg.st) begin
            r_next.tmr = '0;
        end

        r_next.sym = (!rx_on || tick) ? 10'h000 : r_reg.sym + 10'h001;

        // energy state with hysteresis, released below threshold minus hysteresis or whenever strength is not valid
        if (!valid) begin
            r_next.clr_st = 1'b1;
        end else if (r_reg.clr_st && $signed(avg_bus.avg) >= $signed(r_reg.thr)) begin
            r_next.clr_st = 1'b0;
        end else if (!r_reg.clr_st && $signed({avg_bus.avg[7], avg_bus.avg}) < lower) begin
            r_next.clr_st = 1'b1;
        end

        // correlation over the eight symbols after the delimiter
        if (!rx_on) begin
            r_next.cbusy = 1'b0;
        end else if (SFD_DETECT) begin
            r_next.cbusy = 1'b1;
            r_next.ccnt = '0;
            r_next.csum = '0;
        end else if (tick && r_reg.cbusy) begin
            r_next.csum = r_reg.csum + {3'h0, CORR_SAMPLE};
            r_next.ccnt = r_reg.ccnt + 3'h1;
            if (r_reg.ccnt == 3'h7) begin
                r_next.cbusy = 1'b0;
                r_next.corr = r_next.csum[9:3];
            end
        end

        // appended status per frame when auto checksum is on
        if (FRAME_DONE && r_reg.acs) begin
            r_next.frm = {CRC_OK, avg_bus.avg, r_reg.corr};
            r_next.app = 1'b1;
        end

        // oscillator frequency, 2 MHz low on the receive side
        if (r_next.st == ST_RX_CAL || r_next.st == ST_RX) begin
            r_next.lo = LO_BASE + {2'h0, r_reg.carrier_frequency_word} - IF_OFS;
        end else begin
            r_next.lo = LO_BASE + {2'h0, r_reg.carrier_frequency_word};
        end
        // power level from the low five bits of transmit control
        r_next.pa = r_reg.txc[4:0];
        r_next.reg_on = REGULATOR_ENABLE_PIN;
        // pin polarity; an unqualified result reads as busy
        r_next.cca_pin = cca_ok ^ r_reg.inv;
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            r_reg <= '{st: ST_IDLE, mode: MODE_RST, hyst: HYST_RST, thr: THR_RST,
                       carrier_frequency_word: CARRIER_FREQUENCY_WORD_RST, txc: TXC_RST, clr_st: 1'b1, lo: LO_BASE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign AVS_READDATA = r_reg.rdata;
    assign CCA_OUT = r_reg.cca_pin;
    assign RX_ENABLE = rx_on;
    assign TX_ENABLE = (r_reg.st == ST_TX);
    assign CAL_ACTIVE = (r_reg.st == ST_RX_CAL) || (r_reg.st == ST_TX_CAL) ||
                        (r_reg.st == ST_ACK_CAL);
    assign LO_CARRIER_FREQUENCY_WORD_MHZ = r_reg.lo;
    assign POWER_AMP_SETTING = r_reg.pa;
    assign REGULATOR_ON = r_reg.reg_on;
    assign APPEND_STROBE = r_reg.app;

    // helper: cycles spent in receive, saturating
    logic [13:0] rx_age;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_age <= '0;
        end else if (!rx_on) begin
            rx_age <= '0;
        end else if (rx_age != 14'h3fff) begin
            rx_age <= rx_age + 14'h0001;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    a_bus_one_wait: assert property (req && !r_reg.ack |=> !AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    a_valid_eight_sym: assert property (valid |-> rx_age >= 14'(QUAL_CYC))
        else $error("strength valid before eight symbols");
    a_valid_cleared: assert property (!rx_on |=> !valid)
        else $error("valid flag survived receiver off");
    a_pin_when_invalid: assert property (!valid ##1 1'b1 |-> CCA_OUT == $past(r_reg.inv))
        else $error("clear channel pin not idle level");
    a_cond_blocked: assert property (rx_on && wd[STB_COND_TX] && !wd[STB_TX_ON] && !cca_ok
                                     |=> r_reg.st != ST_TX_CAL)
        else $error("conditional transmit started on busy channel");
    a_cond_starts: assert property (rx_on && wd[STB_COND_TX] && !wd[STB_OFF] && cca_ok
                                    |=> tx_active)
        else $error("conditional transmit did not start");
    a_lo_rx_offset: assert property (rx_on && !wd[STB_OFF] && !wd[STB_TX_ON] &&
                                     !wd[STB_COND_TX] && !ACK_REQUEST
                                     |=> LO_CARRIER_FREQUENCY_WORD_MHZ ==
                                         LO_BASE + {2'h0, $past(r_reg.carrier_frequency_word)} - IF_OFS)
        else $error("receive oscillator not 2 MHz below carrier");
    a_cal_before_tx: assert property ($rose(TX_ENABLE) |-> $past(CAL_ACTIVE))
        else $error("transmit entered without calibration");

    c_valid_rise: cover property ($rose(valid));
    c_cond_tx: cover property (rx_on && wd[STB_COND_TX] && cca_ok);
    c_append: cover property (APPEND_STROBE);
endmodule

// ---- test/ssc_demod_model.sv ----
// demodulator stand-in that feeds strength, correlation and frame events to the block
`timescale 1ns/1ps
module ssc_demod_model (
    // clock and radio state
    input wire logic clk,
    input wire logic rx_on,
    // measurements toward the block
    output logic signed [7:0] strength,
    output logic [6:0] corr,
    output logic sfd,
    output logic done,
    output logic crc_ok,
    output logic frame_active
);
    logic signed [7:0] lvl = 8'shec;
    logic alt = 1'b1;
    logic odd = 1'b0;
    int cnt = 0;

    // quiet lines until the bench asks for a frame
    initial begin
        corr = 7'h6e;
        sfd = 1'b0;
        done = 1'b0;
        crc_ok = 1'b0;
        frame_active = 1'b0;
    end

    // level flips mid-symbol so the block never samples it while it moves
    always @(posedge clk) begin
        cnt <= rx_on ? cnt + 1 : 0;
        if (rx_on && (cnt % 800 == 400)) begin
            odd <= ~odd;
        end
    end

    // alternating mode gives two levels 4 dB apart, so a plain copy fails
    assign strength = (alt && odd) ? lvl - 8'sh04 : lvl;

    // delimiter, eight symbols and more of payload, then the frame end
    task automatic frame();
        sfd <= 1'b1;
        @(posedge clk);
        sfd <= 1'b0;
        repeat (6500) @(posedge clk);
        done <= 1'b1;
        crc_ok <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        crc_ok <= 1'b0;
    endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the strength, clear channel and channel control block
`timescale 1ns/1ps
module tb;
    import ssc_pkg::*;
    localparam int CAL = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic wait_req;
    logic signed [7:0] samp;
    logic [6:0] corr;
    logic sfd, done, crc, fa, cca, rx_en, tx_en, cal, reg_on, app;
    logic reg_pin = 1'b1;
    logic ack_req = 1'b0;
    logic tx_done = 1'b0;
    logic [11:0] lo;
    logic [4:0] pa;
    logic [31:0] q;
    int fails = 0;
    int checks = 0;

    always #10 clk = ~clk;

    ssc_ctrl #(.CAL_CYC(CAL)) DUT (.SYS_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .STRENGTH_SAMPLE(samp),
        .CORR_SAMPLE(corr), .SFD_DETECT(sfd), .FRAME_DONE(done), .CRC_OK(crc),
        .RX_FRAME_ACTIVE(fa), .ACK_REQUEST(ack_req), .TX_DONE(tx_done),
        .REGULATOR_ENABLE_PIN(reg_pin), .CCA_OUT(cca), .RX_ENABLE(rx_en), .TX_ENABLE(tx_en),
        .CAL_ACTIVE(cal), .LO_CARRIER_FREQUENCY_WORD_MHZ(lo), .POWER_AMP_SETTING(pa), .REGULATOR_ON(reg_on),
        .APPEND_STROBE(app));

    ssc_demod_model model (.clk(clk), .rx_on(rx_en), .strength(samp), .corr(corr),
        .sfd(sfd), .done(done), .crc_ok(crc), .frame_active(fa));

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    task complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        addr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        // sample waitrequest and read data at the rising edge itself
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wait_req === 1'b0) begin
                q = rdat;
                break;
            end
        end
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20) begin
            chk_reg(32'h0, 32'h1);
            complete_run();
        end
        @(posedge clk);
    endtask

    task automatic t_reset();
        bus(0, OFS_MODEM, 0);
        chk_reg(q, 32'h13);
        bus(0, OFS_THRESH, 0);
        chk_reg(q, 32'he0);
        bus(0, OFS_SYNTH, 0);
        chk_reg(q, 32'h165);
        bus(0, OFS_TX_CONTROL, 0);
        chk_reg(q, 32'ha0ff);
        bus(0, 5'h1c, 0);
        chk_reg(q, 32'h0);
        chk_pin(12'(pa), 12'h1f);
        chk_pin(lo, 12'h965);
        chk_pin(12'(reg_on), 12'h1);
        $display("reset values done");
    endtask

    task automatic t_power();
        bus(1, OFS_TX_CONTROL, 32'ha0e3);
        cyc(2);
        chk_pin(12'(pa), 12'h3);
        $display("power level done");
    endtask

    task automatic t_rx();
        int n;
        bus(1, OFS_SYNTH, 32'(357 + 5 * (26 - 11)));
        bus(1, OFS_STROBE, 32'h1);
        chk_pin(12'(cal), 12'h1);
        chk_pin(lo, 12'h9ae);
        cyc(6300);
        bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[9:8]), 12'h0);
        for (n = 0; n < 100 && q[8] !== 1'b1; n++) bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[9:8]), 12'h3);
        chk_reg(32'(q[7:0]), 32'hea);
        model.alt <= 1'b0;
        model.lvl <= 8'shf6;
        cyc(9 * 800);
        bus(0, OFS_STATUS, 0);
        chk_reg(32'(q[7:0]), 32'hf6);
        $display("strength done");
    endtask

    task automatic t_cca();
        bus(1, OFS_THRESH, 32'hf0);
        cyc(3);
        chk_pin(12'(cca), 12'h0);
        bus(1, OFS_THRESH, 32'hf7);
        cyc(3);
        chk_pin(12'(cca), 12'h0);
        bus(1, OFS_THRESH, 32'hf9);
        cyc(3);
        chk_pin(12'(cca), 12'h1);
        bus(1, OFS_MODEM, 32'h53);
        cyc(3);
        chk_pin(12'(cca), 12'h0);
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 2; f++) begin
                model.frame_active <= f[0];
                bus(1, OFS_MODEM, 32'h10 | 32'(m));
                cyc(3);
                chk_pin(12'(cca), 12'((m == 1) || (f == 0 && m >= 2)));
            end
        end
        model.frame_active <= 1'b0;
        $display("clear channel done");
    endtask

    task automatic t_frame();
        int n;
        bus(1, OFS_MODEM, 32'h17);
        model.frame();
        for (n = 0; n < 4 && app !== 1'b1; n++) @(negedge clk);
        chk_pin(12'(app), 12'h1);
        @(posedge clk);
        bus(0, OFS_FRAME, 0);
        chk_reg(q, 32'hfb6e);
        $display("frame append done");
    endtask

    task automatic t_ctx();
        bus(1, OFS_MODEM, 32'h10);
        bus(1, OFS_STROBE, 32'h4);
        bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[12:10]), 12'h0);
        chk_pin(12'(rx_en), 12'h1);
        bus(1, OFS_MODEM, 32'h11);
        cyc(3);
        bus(1, OFS_STROBE, 32'h4);
        chk_pin(12'(cal), 12'h1);
        chk_pin(lo, 12'h9b0);
        bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[12:10]), 12'h3);
        cyc(CAL);
        chk_pin(12'(tx_en), 12'h1);
        // transmit end recalibrates for receive, an ack request for transmit
        tx_done <= 1'b1;
        cyc(1);
        tx_done <= 1'b0;
        cyc(1);
        chk_pin(12'(cal), 12'h1);
        chk_pin(lo, 12'h9ae);
        cyc(CAL);
        ack_req <= 1'b1;
        cyc(1);
        ack_req <= 1'b0;
        cyc(1);
        chk_pin(12'(cal), 12'h1);
        chk_pin(lo, 12'h9b0);
        cyc(CAL);
        chk_pin(12'(tx_en), 12'h1);
        bus(1, OFS_STROBE, 32'h8);
        bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[9:8]), 12'h0);
        bus(1, OFS_STROBE, 32'h1);
        cyc(CAL + 5);
        bus(0, OFS_STATUS, 0);
        chk_pin(12'(q[9:8]), 12'h0);
        $display("conditional transmit done");
    endtask

    task automatic t_regulator();
        // device held in reset before the regulator is dropped
        nrst <= 1'b0;
        cyc(1);
        reg_pin <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(3);
        chk_pin(12'(reg_on), 12'h0);
        reg_pin <= 1'b1;
        cyc(2);
        chk_pin(12'(reg_on), 12'h1);
        $display("regulator done");
    endtask

    // gain loop settings are never written, only the block's own map
    initial begin
        cyc(2);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_power();
        t_rx();
        t_cca();
        t_frame();
        t_ctx();
        t_regulator();
        complete_run();
    end
endmodule
